// *** tpc_pkg.sv ***
// shared constants, seed table and carrier types for the test pattern block
package tpc_pkg;

	// ----------------------------------------------------------------
	// stream and sequence geometry
	// ----------------------------------------------------------------
	localparam int NUM_STREAMS = 32;
	localparam int IDX_W = 5;
	localparam int LFSR_W = 15;
	localparam int SEQ_LEN = 32767; // maximal length of a 15-bit register
	localparam int CNT_W = 32;
	localparam int PERIOD_W = 8;
	localparam int SYNC_W = 2;

	// feedback taps x^15 + x^14 + 1, msb of the register is the output bit
	localparam int TAP_HI = 14;
	localparam int TAP_LO = 13;

	// ----------------------------------------------------------------
	// values after reset, and the last stream index
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
	localparam logic [PERIOD_W-1:0] PERIOD_RST = 8'h00;
	localparam logic [IDX_W-1:0] IDX_RST = 5'h00;
	localparam logic [IDX_W-1:0] IDX_LAST = 5'h1f;

	// ----------------------------------------------------------------
	// per-stream start states: the first fifteen bits after a tick,
	// oldest bit in the msb; stream 0 is a plain non-zero default
	// ----------------------------------------------------------------
	localparam logic [NUM_STREAMS-1:0][LFSR_W-1:0] SEED_TABLE = {
		15'h7ffe, 15'h3f75, 15'h5fba, 15'h4f98, 15'h77ee, 15'h63c4, 15'h75ea, 15'h74e8,
		15'h7f7e, 15'h7a34, 15'h7d5a, 15'h7c48, 15'h7f76, 15'h7e60, 15'h7f74, 15'h7f75,
		15'h0001, 15'h408a, 15'h2045, 15'h3067, 15'h0811, 15'h1c3b, 15'h0a15, 15'h0b17,
		15'h0081, 15'h05cb, 15'h02a5, 15'h03b7, 15'h0089, 15'h019f, 15'h008b, 15'h4000
	};

	// ----------------------------------------------------------------
	// bits 16 to 20 after a tick, per stream, bit 16 in the msb; the
	// register gives bits 1 to 15 and everything after bit 20, so a
	// wrap without a tick repeats register bits there, not this tail
	// ----------------------------------------------------------------
	localparam int TAIL_W = 5;
	localparam int STEP_W = 5;
	localparam logic [STEP_W-1:0] STEP_RST = 5'h00;
	localparam logic [STEP_W-1:0] HEAD_LAST = 5'h0e; // samples 0 to 14 come from the seed
	localparam logic [STEP_W-1:0] TABLE_LAST = 5'h13; // sample 19 is the last table bit
	localparam logic [STEP_W-1:0] STEP_DONE = 5'h14; // count saturates past the table
	// stream 0 tail is arbitrary, like its seed
	localparam logic [NUM_STREAMS-1:0][TAIL_W-1:0] TAIL_TABLE = {
		5'h1f, 5'h0f, 5'h07, 5'h0b, 5'h19, 5'h16, 5'h18, 5'h18,
		5'h1f, 5'h1c, 5'h1e, 5'h1e, 5'h1f, 5'h1f, 5'h1f, 5'h1f,
		5'h00, 5'h10, 5'h18, 5'h14, 5'h06, 5'h09, 5'h07, 5'h07,
		5'h00, 5'h03, 5'h01, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00
	};

	// ----------------------------------------------------------------
	// checker sequencing and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {CHK_IDLE, CHK_ALIGN, CHK_MEASURE, CHK_REPORT} tpc_chk_state_t;

	typedef struct packed {
		logic start; // one-cycle request, taken only while idle
		logic sequential; // 1: one stream per period, 0: all streams at once
		logic [PERIOD_W-1:0] periods; // whole tick periods per report, 0 counts as 1
		logic [IDX_W-1:0] refOffset; // stream s is checked against reference s+refOffset
	} tpc_cmd_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [IDX_W-1:0] stream;
		logic [IDX_W-1:0] refIdx;
		logic [CNT_W-1:0] errors;
		logic [CNT_W-1:0] ones;
		logic [CNT_W-1:0] bits;
	} tpc_report_t;

endpackage

// *** tpc_pattern_unit.sv ***
// test pattern generator and checker for thirty-two parallel bit-streams
`timescale 1ns/1ns
// Notes on behaviour
// - every second tick restarts the generator sequences
// - one step per sample, timed like data
// - runs its 32767-bit sequence until next tick
// - first bits after tick follow per-stream table
// - checker reports error count and ones count
// - checks all streams sequentially or simultaneously
// - any stream against any reference sequence
// - reporting period is whole tick periods only
// - tick-aligned bit flagged at every sample rate
module tpc_pattern_unit (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic secondTick,
	input wire logic sampleEn,
	input wire logic [tpc_pkg::NUM_STREAMS-1:0] rxStream,
	input wire tpc_pkg::tpc_cmd_t cmd,
	output logic [tpc_pkg::NUM_STREAMS-1:0] testPattern,
	output logic tickAlignedBit,
	output logic checkBusy,
	output tpc_pkg::tpc_report_t report
);
	import tpc_pkg::*;

	// ----------------------------------------------------------------
	// state of the whole unit
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [SYNC_W-1:0] tickSync;
		logic tickPrev;
		logic [NUM_STREAMS-1:0] rxMeta;
		logic [NUM_STREAMS-1:0] rxSync;
		logic [SYNC_W:0] sampleDly;
		logic [NUM_STREAMS-1:0][LFSR_W-1:0] genLfsr;
		logic [STEP_W-1:0] genCount;
		logic [NUM_STREAMS-1:0] patternOut;
		logic tickPending;
		logic tickFlag;
		logic [NUM_STREAMS-1:0][LFSR_W-1:0] refLfsr;
		logic [STEP_W-1:0] refCount;
		tpc_chk_state_t chk;
		logic busy;
		tpc_cmd_t cmdHeld;
		logic [IDX_W-1:0] streamIdx;
		logic [IDX_W-1:0] rptIdx;
		logic [PERIOD_W-1:0] tickCount;
		logic [CNT_W-1:0] bitCount;
		logic [NUM_STREAMS-1:0][CNT_W-1:0] errCnt;
		logic [NUM_STREAMS-1:0][CNT_W-1:0] onesCnt;
		tpc_report_t rpt;
	} tpc_state_t;

	tpc_state_t st_reg;
	tpc_state_t st_next;
	logic tickRise;
	logic periodEnd;
	logic [PERIOD_W-1:0] ticksSeen;

	// one step of the feedback shift register
	function automatic logic [LFSR_W-1:0] lfsrStep(input logic [LFSR_W-1:0] s);
		lfsrStep = {s[LFSR_W-2:0], s[TAP_HI] ^ s[TAP_LO]};
	endfunction

	// register msb, except bits 16 to 20 after a tick, which come from the tail table
	function automatic logic seqBit(input logic [IDX_W-1:0] s, input logic [STEP_W-1:0] c,
		input logic [LFSR_W-1:0] r);
		logic [STEP_W-1:0] pos;
		pos = TABLE_LAST - c;
		if (c > HEAD_LAST && c <= TABLE_LAST) begin
			seqBit = TAIL_TABLE[s][pos[2:0]];
		end else begin
			seqBit = r[LFSR_W-1];
		end
	endfunction

	// samples since the tick, saturating once the table is behind
	function automatic logic [STEP_W-1:0] countStep(input logic [STEP_W-1:0] c);
		countStep = (c == STEP_DONE) ? c : c + 5'h01;
	endfunction

	// ----------------------------------------------------------------
	// tick edge and period bookkeeping
	// ----------------------------------------------------------------
	// only the second synchroniser stage feeds the edge detector
	assign tickRise = st_reg.tickSync[SYNC_W-1] & ~st_reg.tickPrev;
	assign ticksSeen = st_reg.tickCount + 8'h01;
	assign periodEnd = tickRise && (ticksSeen >= st_reg.cmdHeld.periods);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [IDX_W-1:0] refSel;
		logic rxBit;
		refSel = IDX_RST;
		rxBit = 1'b0;
		st_next = st_reg;

		// pin inputs pass two flops; sample enable is delayed by the output flop
		// and both sync flops, so a looped-back bit meets its own reference bit
		st_next.tickSync = {st_reg.tickSync[0], secondTick};
		st_next.tickPrev = st_reg.tickSync[SYNC_W-1];
		st_next.rxMeta = rxStream;
		st_next.rxSync = st_reg.rxMeta;
		st_next.sampleDly = {st_reg.sampleDly[SYNC_W-1:0], sampleEn};

		if (tickRise) begin
			st_next.genLfsr = SEED_TABLE;
			st_next.genCount = STEP_RST;
			st_next.tickPending = 1'b1;
		end else if (sampleEn) begin
			st_next.genCount = countStep(st_reg.genCount);
			for (int i = 0; i < NUM_STREAMS; i++) begin
				st_next.patternOut[i] = seqBit(IDX_W'(i), st_reg.genCount, st_reg.genLfsr[i]);
				st_next.genLfsr[i] = lfsrStep(st_reg.genLfsr[i]);
			end
			st_next.tickFlag = st_reg.tickPending;
			st_next.tickPending = 1'b0;
		end

		if (tickRise) begin
			st_next.refLfsr = SEED_TABLE;
			st_next.refCount = STEP_RST;
		end else if (st_reg.sampleDly[SYNC_W]) begin
			st_next.refCount = countStep(st_reg.refCount);
			for (int i = 0; i < NUM_STREAMS; i++) begin
				st_next.refLfsr[i] = lfsrStep(st_reg.refLfsr[i]);
			end
		end

		// report strobe lasts a single cycle
		st_next.rpt.valid = 1'b0;
		st_next.rpt.last = 1'b0;

		case (st_reg.chk)
			CHK_IDLE: begin
				if (cmd.start) begin
					st_next.cmdHeld = cmd;
					st_next.streamIdx = IDX_RST;
					st_next.chk = CHK_ALIGN;
				end
			end
			CHK_ALIGN: begin
				// counting starts only on a tick so the period is whole
				if (tickRise) begin
					st_next.errCnt = '0;
					st_next.onesCnt = '0;
					st_next.bitCount = CNT_RST;
					st_next.tickCount = PERIOD_RST;
					st_next.chk = CHK_MEASURE;
				end
			end
			CHK_MEASURE: begin
				// the bit on the tick itself is undefined and not counted
				if (st_reg.sampleDly[SYNC_W] && !tickRise) begin
					st_next.bitCount = st_reg.bitCount + 32'h1;
					for (int i = 0; i < NUM_STREAMS; i++) begin
						if (!st_reg.cmdHeld.sequential || IDX_W'(i) == st_reg.streamIdx) begin
							refSel = IDX_W'(i) + st_reg.cmdHeld.refOffset;
							rxBit = st_reg.rxSync[i];
							st_next.errCnt[i] = st_reg.errCnt[i]
								+ {31'h0, rxBit ^ seqBit(refSel, st_reg.refCount,
								st_reg.refLfsr[refSel])};
							st_next.onesCnt[i] = st_reg.onesCnt[i] + {31'h0, rxBit};
						end
					end
				end
				if (tickRise) begin
					st_next.tickCount = ticksSeen;
				end
				if (periodEnd) begin
					if (st_reg.cmdHeld.sequential) begin
						st_next.rpt.valid = 1'b1;
						st_next.rpt.last = (st_reg.streamIdx == IDX_LAST);
						st_next.rpt.stream = st_reg.streamIdx;
						st_next.rpt.refIdx = st_reg.streamIdx + st_reg.cmdHeld.refOffset;
						st_next.rpt.errors = st_reg.errCnt[st_reg.streamIdx];
						st_next.rpt.ones = st_reg.onesCnt[st_reg.streamIdx];
						st_next.rpt.bits = st_reg.bitCount;
						// next stream starts on this very tick, its counters are still clear
						st_next.streamIdx = st_reg.streamIdx + 5'h01;
						st_next.tickCount = PERIOD_RST;
						st_next.bitCount = CNT_RST;
						if (st_reg.streamIdx == IDX_LAST) begin
							st_next.chk = CHK_IDLE;
						end
					end else begin
						st_next.rptIdx = IDX_RST;
						st_next.chk = CHK_REPORT;
					end
				end
			end
			CHK_REPORT: begin
				st_next.rpt.valid = 1'b1;
				st_next.rpt.last = (st_reg.rptIdx == IDX_LAST);
				st_next.rpt.stream = st_reg.rptIdx;
				st_next.rpt.refIdx = st_reg.rptIdx + st_reg.cmdHeld.refOffset;
				st_next.rpt.errors = st_reg.errCnt[st_reg.rptIdx];
				st_next.rpt.ones = st_reg.onesCnt[st_reg.rptIdx];
				st_next.rpt.bits = st_reg.bitCount;
				st_next.rptIdx = st_reg.rptIdx + 5'h01;
				if (st_reg.rptIdx == IDX_LAST) begin
					st_next.chk = CHK_IDLE;
				end
			end
			default: begin
				st_next.chk = CHK_IDLE;
			end
		endcase

		// busy is kept in its own flop so the output needs no decoding
		st_next.busy = (st_next.chk != CHK_IDLE);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// sequences are seeded at reset so the outputs are defined before the first tick
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.genLfsr <= SEED_TABLE;
			st_reg.refLfsr <= SEED_TABLE;
			st_reg.chk <= CHK_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign testPattern = st_reg.patternOut;
	assign tickAlignedBit = st_reg.tickFlag;
	assign checkBusy = st_reg.busy;
	assign report = st_reg.rpt;

endmodule

// *** tpc_far_end.sv ***
// far end model: loops the pattern back, corrupting chosen streams
`timescale 1ns/1ns
module tpc_far_end (
	input wire logic [31:0] txStream,
	input wire logic [31:0] flipMask,
	output logic [31:0] rxStream
);
	// inverting a stream turns every bit of it into an error
	assign rxStream = txStream ^ flipMask;
endmodule

// *** tpc_pattern_checker.sv ***
// port assertions for the test pattern unit
`timescale 1ns/1ns
module tpc_pattern_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic secondTick,
	input wire logic sampleEn,
	input wire logic [31:0] rxStream,
	input wire tpc_pkg::tpc_cmd_t cmd,
	input wire logic [31:0] testPattern,
	input wire logic tickAlignedBit,
	input wire logic checkBusy,
	input wire tpc_pkg::tpc_report_t report
);
	import tpc_pkg::*;
	// ------------
	// one clock domain
	// ------------
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_pattern_hold: assert property (!$past(sampleEn) |-> $stable(testPattern))
		else $error("pattern moved without a sample");
	a_tick_rise: assert property ($rose(tickAlignedBit) |-> $past(sampleEn))
		else $error("tick bit rose without a sample");
	a_tick_length: assert property (tickAlignedBit && sampleEn |=> !tickAlignedBit)
		else $error("tick bit outlived its sample");
	a_busy_start: assert property ($rose(checkBusy) |-> $past(cmd.start))
		else $error("busy without a start");
	a_last_idle: assert property (report.valid && report.last && !cmd.start |=> !checkBusy)
		else $error("busy after last report");
	a_ref_offset: assert property (report.valid |->
		report.refIdx == IDX_W'(report.stream + cmd.refOffset))
		else $error("wrong reference index");
	a_count_bound: assert property (report.valid |->
		report.errors <= report.bits && report.ones <= report.bits)
		else $error("count exceeds bits");
	a_stream_step: assert property (report.valid && !report.last && !cmd.sequential
		|=> report.valid && report.stream == $past(report.stream) + 5'h1)
		else $error("reports not consecutive");
	a_report_tick: assert property ($rose(report.valid) |->
		$past(secondTick, 3) || $past(secondTick, 5))
		else $error("report not on a tick");
endmodule
bind tpc_pattern_unit tpc_pattern_checker i_chk (.mclk, .rst_n, .secondTick, .sampleEn,
	.rxStream, .cmd, .testPattern, .tickAlignedBit, .checkBusy, .report);

// *** tb.sv ***
// self-checking testbench for the test pattern unit
`timescale 1ns/1ns
module tb;
	import tpc_pkg::*;
	localparam int N = 40;
	logic mclk = 0, rst_n = 0, secondTick = 0, sampleEn = 0;
	logic [31:0] rxStream, testPattern, flipMask = '0;
	logic tickAlignedBit, checkBusy;
	tpc_cmd_t cmd = '0;
	tpc_report_t report;
	tpc_report_t rep[32];
	logic [LFSR_W-1:0] st[32];
	int failures = 0, checked = 0, cycles = 0, nrep = 0, pos = 0;
	initial begin
		forever #50 mclk = ~mclk;
	end
	tpc_far_end i_far (.txStream(testPattern), .flipMask, .rxStream);
	tpc_pattern_unit i_dut (.mclk, .rst_n, .secondTick, .sampleEn, .rxStream, .cmd,
		.testPattern, .tickAlignedBit, .checkBusy, .report);
	// ------------
	// capture and helpers
	// ------------
	// reports stored by stream; the cycle ceiling cuts a hang short
	always @(posedge mclk) begin
		cycles++;
		if (report.valid === 1'h1) begin
			rep[report.stream] = report;
			nrep++;
		end
		if (cycles == 50000) begin
			failures++;
			stop_test();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// expected bits now, then one feedback step; seeds reload per tick,
	// bits 16 to 20 after the tick come from the tail table
	function automatic logic [31:0] step();
		logic [31:0] b;
		for (int i = 0; i < 32; i++) begin
			b[i] = (pos >= 15 && pos < 20) ? TAIL_TABLE[i][19 - pos] : st[i][14];
			st[i] = {st[i][13:0], st[i][14] ^ st[i][13]};
		end
		pos++;
		return b;
	endfunction
	// tick pulse then a quiet gap, so no sample lands on the reload
	task automatic frame(input int n);
		secondTick = 1;
		repeat (2) @(posedge mclk);
		#1 secondTick = 0;
		repeat (8) @(posedge mclk);
		#1 sampleEn = 1;
		for (int i = 0; i < 32; i++)
			st[i] = SEED_TABLE[i];
		pos = 0;
		for (int k = 1; k <= n; k++) begin
			@(posedge mclk);
			#1;
			cmp(testPattern, step());
			if (k < 3)
				cmp({31'h0, tickAlignedBit}, {31'h0, k == 1});
		end
		sampleEn = 0;
		repeat (6) @(posedge mclk);
		#1;
	endtask
	// one measurement; counts worked out from the reference model
	task automatic measure(input logic sq, input logic [7:0] per, input logic [4:0] off);
		int e[32], o[32];
		logic [31:0] b, r;
		rep = '{default: '0};
		nrep = 0;
		cmd = '{1'h1, sq, per, off};
		@(posedge mclk);
		#1 cmd.start = 1'h0;
		cmp({31'h0, checkBusy}, 32'h1);
		repeat (sq ? 33 : per + 1) frame(N);
		repeat (40) @(posedge mclk);
		#1;
		cmp(nrep, 32);
		cmp({31'h0, checkBusy}, 32'h0);
		for (int i = 0; i < 32; i++)
			st[i] = SEED_TABLE[i];
		pos = 0;
		for (int k = 0; k < N; k++) begin
			b = step();
			r = b ^ flipMask;
			for (int s = 0; s < 32; s++) begin
				o[s] += r[s];
				e[s] += r[s] ^ b[(s + off) % 32];
			end
		end
		for (int s = 0; s < 32; s++) begin
			cmp(rep[s].errors, e[s] * per);
			cmp(rep[s].ones, o[s] * per);
			cmp(rep[s].bits, N * per);
			cmp({27'h0, rep[s].refIdx}, (s + off) % 32);
			cmp({31'h0, rep[s].last}, {31'h0, s == 31});
		end
	endtask
	task automatic stop_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ------------
	// main sequence
	// ------------
	initial begin
		repeat (16) @(posedge mclk);
		#1 rst_n = 1;
		frame(SEQ_LEN + 20);
		frame(20);
		flipMask = 32'h8000_0005;
		measure(1'h0, 8'h02, 5'h00);
		flipMask = 32'h0000_0000;
		measure(1'h1, 8'h01, 5'h01);
		stop_test();
	end
endmodule
